// file: hdl/lna_tgc_defs.svh
// Purpose: Offsets, field positions, reset values and decode figures of the gain and time-gain registers.
// Assumes: Offsets are register indexes; the bus byte address is four times the index.
// Notes:   Definitions only.
`ifndef LNA_TGC_DEFS_SVH
`define LNA_TGC_DEFS_SVH

// ============================================================
// Register indexes
`define IDX_INDEP_GAIN      8'hC4
`define IDX_PAIR_GAIN       8'hC9
`define IDX_TGC_HPF         8'hCB
`define IDX_OFFSET_MODE     8'hF0

// ============================================================
// Field positions
`define BIT_INDEP_GAIN_EN   15
`define BIT_OFFSET_MODE     0
`define BIT_ATTEN_EN        7
`define ATTEN_MSB           6
`define ATTEN_LSB           4
`define HPF_MSB             3
`define HPF_LSB             2

// ============================================================
// Reset values
`define RST_PAIR_GAIN       16'h0000
`define RST_TGC_HPF         16'h0000

// ============================================================
// Decode figures
`define GAIN_DB_CODE0       5'h12
`define GAIN_DB_CODE1       5'h18
`define GAIN_DB_CODE2       5'h0C
`define ATTEN_STEP_DB       6'h06
`define ATTEN_MAX_DB        6'h2A
`define HPF_KHZ_CODE0       8'h64
`define HPF_KHZ_CODE1       8'h32
`define HPF_KHZ_CODE2       8'hC8
`define HPF_KHZ_CODE3       8'h96

// ============================================================
// Bus answers
`define RESP_OKAY           2'h0
`define RESP_DECODE_ERR     2'h3

`endif

// file: hdl/lna_tgc_pkg.sv
// Purpose: Types and decode functions shared by the gain and time-gain register bank.
// Assumes: Header of constants is on the include path.
// Notes:   Code 11 of a gain field and code 110 of the attenuation field have no defined meaning.
`include "lna_tgc_defs.svh"
package lna_tgc_pkg;

  // ============================================================
  // Types
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

  typedef logic [1:0] gain_code_t;

  // ============================================================
  // Decoders
  function automatic logic [4:0] gainDb(input gain_code_t code);
    unique case (code)
      2'b00:   gainDb = `GAIN_DB_CODE0;
      2'b01:   gainDb = `GAIN_DB_CODE1;
      2'b10:   gainDb = `GAIN_DB_CODE2;
      default: gainDb = `GAIN_DB_CODE0;
    endcase
  endfunction

  function automatic logic [5:0] attenDb(input logic [2:0] code);
    if (code == 3'b111) begin
      attenDb = `ATTEN_MAX_DB;
    end else begin
      attenDb = 6'(code * `ATTEN_STEP_DB);
    end
  endfunction

  function automatic logic [7:0] hpfKhz(input logic [1:0] code);
    unique case (code)
      2'b00: hpfKhz = `HPF_KHZ_CODE0;
      2'b01: hpfKhz = `HPF_KHZ_CODE1;
      2'b10: hpfKhz = `HPF_KHZ_CODE2;
      2'b11: hpfKhz = `HPF_KHZ_CODE3;
    endcase
  endfunction

endpackage : lna_tgc_pkg

// file: hdl/lna_channel_gain_map.sv
// Purpose: Turns pair gain fields into per-channel LNA gains.
// Assumes: gainWrite pulses for one cycle with the merged register value on gainValue.
// Notes:   Channel 1 is index 0; the even channel of each pair is the odd index.
module lna_channel_gain_map
  import lna_tgc_pkg::*;
#(
  parameter int NUM_PAIRS = 8
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     gainWrite,
  input  wire logic [2*NUM_PAIRS-1:0]   gainValue,
  input  wire logic                     offsetMode,
  input  wire logic                     indepEnable,
  output logic      [10*NUM_PAIRS-1:0]  chanGainDb_r,
  output logic                          indepActive_r
);

  gain_code_t chanCode_r [2*NUM_PAIRS];

  // ============================================================
  // Programming of channel codes
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int c = 0; c < 2*NUM_PAIRS; c++) begin
        chanCode_r[c] <= 2'b00;
      end
    end else if (gainWrite) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        chanCode_r[2*p+1] <= gainValue[2*p +: 2];
        if (!offsetMode) begin
          chanCode_r[2*p] <= gainValue[2*p +: 2];
        end
      end
    end
  end

  // ============================================================
  // Effective gain; without the enable every channel sits at the default 18 dB
  always_ff @(posedge clk) begin
    if (reset) begin
      indepActive_r <= 1'b0;
      for (int c = 0; c < 2*NUM_PAIRS; c++) begin
        chanGainDb_r[5*c +: 5] <= `GAIN_DB_CODE0;
      end
    end else begin
      indepActive_r <= indepEnable;
      for (int c = 0; c < 2*NUM_PAIRS; c++) begin
        chanGainDb_r[5*c +: 5] <= indepEnable ? gainDb(chanCode_r[c]) : `GAIN_DB_CODE0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_odd_held_offset: assert property (gainWrite && offsetMode |=> chanCode_r[0] == $past(chanCode_r[0]))
    else $error("odd channel changed in offset mode");
  a_pair_both_set: assert property (gainWrite && !offsetMode |=> chanCode_r[0] == chanCode_r[1])
    else $error("pair channels differ after shared write");
  a_gain_24db: assert property (gainWrite && !offsetMode && gainValue[1:0] == 2'b01 ##1 indepEnable
                                |=> chanGainDb_r[4:0] == 5'h18)
    else $error("code 01 did not give 24 dB");
  c_offset_write: cover property (gainWrite && offsetMode);

endmodule : lna_channel_gain_map

// file: hdl/tgc_hpf_decode.sv
// Purpose: Decodes the time-gain attenuation and LNA high-pass corner fields.
// Assumes: cfg is the stored configuration register.
// Notes:   Code 110 of the attenuation field is flagged and still decodes to 36 dB.
module tgc_hpf_decode
  import lna_tgc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [15:0] cfg,
  output logic             attenEnable_r,
  output logic [5:0]       attenDb_r,
  output logic             attenCodeInvalid_r,
  output logic [7:0]       hpfCornerKhz_r
);

  logic [2:0] attenCode;
  assign attenCode = cfg[`ATTEN_MSB:`ATTEN_LSB];

  // ============================================================
  // Decode
  always_ff @(posedge clk) begin
    if (reset) begin
      attenEnable_r      <= 1'b0;
      attenDb_r          <= 6'h00;
      attenCodeInvalid_r <= 1'b0;
      hpfCornerKhz_r     <= `HPF_KHZ_CODE0;
    end else begin
      attenEnable_r      <= cfg[`BIT_ATTEN_EN];
      attenDb_r          <= cfg[`BIT_ATTEN_EN] ? attenDb(attenCode) : 6'h00;
      attenCodeInvalid_r <= cfg[`BIT_ATTEN_EN] && attenCode == 3'b110;
      hpfCornerKhz_r     <= hpfKhz(cfg[`HPF_MSB:`HPF_LSB]);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_atten_max: assert property (cfg[7] && cfg[6:4] == 3'b111 |=> attenDb_r == 6'h2A)
    else $error("code 111 did not give 42 dB");
  a_atten_off: assert property (!cfg[7] |=> attenDb_r == 6'h00 && !attenEnable_r)
    else $error("attenuation active while disabled");
  a_hpf_50k: assert property (cfg[3:2] == 2'b01 |=> hpfCornerKhz_r == 8'h32)
    else $error("code 01 did not give 50 kHz");

endmodule : tgc_hpf_decode

// file: hdl/lna_gain_tgc_hpf_cfg_regs.sv
// Purpose: Avalon-MM register bank for pair LNA gain, time-gain attenuation and LNA high-pass corner.
// Assumes: address is a word index; byte address is four times it.
// Notes:   Every access answers with waitrequest low in the cycle after it is seen.
// Notes on behaviour
// - A gain code 00 means 18 dB, 01 means 24 dB, 10 means 12 dB, and 11 must not be written.
// - Channel gains follow the pair fields only while the independent-gain enable is 1.
// - With offset addressing off, a pair field sets both channels of its pair.
// - With offset addressing on, a pair field sets only the even channel and leaves the odd one.
// - The gain register holds eight 2-bit pair fields, pair 1/2 at bits 1-0 up to pair 15/16 at bits 15-14.
// - The time-gain and high-pass register sits at index CBh.
// - Bit 7 of that register turns the digital attenuator on.
// - Bits 6-4 pick 0 to 30 dB in 6 dB steps, and code 111 gives 42 dB.
// - Bits 3-2 pick a high-pass corner of 100, 50, 200 or 150 kHz.
// - Every field of both registers reads back what was last written.
// - The pair gain register sits at index C9h.
//
// The Avalon-MM slave port was decided locally.
module lna_gain_tgc_hpf_cfg_regs
  import lna_tgc_pkg::*;
#(
  parameter int NUM_PAIRS = 8
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic [7:0]               address,
  input  wire logic                     read,
  input  wire logic                     write,
  input  wire logic [31:0]              writedata,
  input  wire logic [3:0]               byteenable,
  output logic      [31:0]              readdata,
  output logic                          waitrequest,
  output logic      [1:0]               response,
  output logic      [10*NUM_PAIRS-1:0]  chanGainDb,
  output logic                          indepGainActive,
  output logic                          attenEnable,
  output logic      [5:0]               attenDb,
  output logic                          attenCodeInvalid,
  output logic      [7:0]               hpfCornerKhz
);

  // ============================================================
  // Storage
  bus_state_t  state_r;
  bus_state_t  state_nxt;
  logic [15:0] pairGain_r;
  logic [15:0] tgcHpf_r;
  logic        indepEn_r;
  logic        offsetMode_r;
  logic [31:0] readdata_r;
  logic        waitrequest_r;
  logic [1:0]  response_r;
  logic        mapped;
  logic [31:0] readMux;
  logic        commit;
  logic        gainWrite;
  logic [15:0] gainMerged;

  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    laneMerge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ============================================================
  // Address decode
  always_comb begin
    mapped  = 1'b1;
    readMux = 32'h0000_0000;
    unique case (address)
      `IDX_PAIR_GAIN:   readMux = {16'h0000, pairGain_r};
      `IDX_TGC_HPF:     readMux = {16'h0000, tgcHpf_r};
      `IDX_INDEP_GAIN:  readMux[`BIT_INDEP_GAIN_EN] = indepEn_r;
      `IDX_OFFSET_MODE: readMux[`BIT_OFFSET_MODE] = offsetMode_r;
      default:          mapped = 1'b0;
    endcase
  end

  // ============================================================
  // Bus handshake: request seen in IDLE, answered in ACK
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      BUS_IDLE: if (read || write) begin
        state_nxt = BUS_ACK;
      end
      BUS_ACK:  state_nxt = BUS_IDLE;
      default:  state_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= BUS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      waitrequest_r <= 1'b1;
      response_r    <= `RESP_OKAY;
      readdata_r    <= 32'h0000_0000;
    end else begin
      waitrequest_r <= !(state_r == BUS_IDLE && (read || write));
      if (state_r == BUS_IDLE && (read || write)) begin
        response_r <= mapped ? `RESP_OKAY : `RESP_DECODE_ERR;
        readdata_r <= read ? readMux : 32'h0000_0000;
      end
    end
  end

  assign readdata    = readdata_r;
  assign waitrequest = waitrequest_r;
  assign response    = response_r;

  // Writes land on the edge at which waitrequest is sampled low
  assign commit     = state_r == BUS_ACK && write;
  assign gainMerged = laneMerge(pairGain_r, writedata, byteenable);
  assign gainWrite  = commit && address == `IDX_PAIR_GAIN;

  // ============================================================
  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      pairGain_r <= `RST_PAIR_GAIN;
    end else if (gainWrite) begin
      pairGain_r <= gainMerged;
    end
  end

  // Reserved bits are stored as written; zeros there are software's duty
  always_ff @(posedge clk) begin
    if (reset) begin
      tgcHpf_r <= `RST_TGC_HPF;
    end else if (commit && address == `IDX_TGC_HPF) begin
      tgcHpf_r <= laneMerge(tgcHpf_r, writedata, byteenable);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      indepEn_r    <= 1'b0;
      offsetMode_r <= 1'b0;
    end else if (commit) begin
      if (address == `IDX_INDEP_GAIN && byteenable[1]) begin
        indepEn_r <= writedata[`BIT_INDEP_GAIN_EN];
      end
      if (address == `IDX_OFFSET_MODE && byteenable[0]) begin
        offsetMode_r <= writedata[`BIT_OFFSET_MODE];
      end
    end
  end

  // ============================================================
  // Consumers
  lna_channel_gain_map #(
    .NUM_PAIRS (NUM_PAIRS)
  ) u_gain_map (
    .clk           (clk),
    .reset         (reset),
    .gainWrite     (gainWrite),
    .gainValue     (gainMerged[2*NUM_PAIRS-1:0]),
    .offsetMode    (offsetMode_r),
    .indepEnable   (indepEn_r),
    .chanGainDb_r  (chanGainDb),
    .indepActive_r (indepGainActive)
  );

  tgc_hpf_decode u_tgc_decode (
    .clk                (clk),
    .reset              (reset),
    .cfg                (tgcHpf_r),
    .attenEnable_r      (attenEnable),
    .attenDb_r          (attenDb),
    .attenCodeInvalid_r (attenCodeInvalid),
    .hpfCornerKhz_r     (hpfCornerKhz)
  );

  // ============================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_answer_within: assert property ((read || write) |-> ##[0:2] !waitrequest)
    else $error("no answer within two cycles");
  a_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low two cycles running");
  a_gain_store: assert property (!waitrequest && write && address == 8'hC9 && byteenable[1:0] == 2'b11
                                 |=> pairGain_r == $past(writedata[15:0]))
    else $error("pair gain write not stored");
  a_tgc_readback: assert property (!waitrequest && read && address == 8'hCB
                                   |-> readdata == {16'h0000, tgcHpf_r})
    else $error("time-gain register read mismatch");
  a_unmapped_err: assert property (!waitrequest && !mapped |-> response == 2'h3)
    else $error("unmapped access not flagged");
  a_reset_zero: assert property ($past(reset) |-> pairGain_r == 16'h0000 && tgcHpf_r == 16'h0000)
    else $error("registers not zero after reset");
  a_indep_gates: assert property (!indepEn_r ##1 !indepEn_r |-> chanGainDb == {(2*NUM_PAIRS){5'h12}})
    else $error("channel gain moved while independent gain off");
  a_mapped_okay: assert property (!waitrequest && mapped |-> response == 2'h0)
    else $error("mapped access flagged as error");

  c_read_ack: cover property (read && !waitrequest);
  c_write_ack: cover property (write && !waitrequest && address == 8'hCB);
  c_unmapped: cover property (!waitrequest && !mapped);

endmodule : lna_gain_tgc_hpf_cfg_regs

// file: verification/lna_gain_tgc_hpf_cfg_regs_test.sv
// Purpose: Self-checking bench for the gain and time-gain register bank.
// Assumes: One access answers one cycle after it is seen; derived outputs settle within three edges.
// Notes:   Gain code 11 and attenuation code 110 are never written.
`include "lna_tgc_defs.svh"
module lna_gain_tgc_hpf_cfg_regs_test
  import lna_tgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ============================================================
  // Signals
  logic        clk;
  logic        reset;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [1:0]  response;
  logic [79:0] chanGainDb;
  logic        indepGainActive;
  logic        attenEnable;
  logic [5:0]  attenDb;
  logic        attenCodeInvalid;
  logic [7:0]  hpfCornerKhz;
  logic [4:0]  chanExp [16];
  logic        offsetOn;
  logic        indepOn;
  int          errCount;
  int          nCompared;

  lna_gain_tgc_hpf_cfg_regs u_lna_gain_tgc_hpf_cfg_regs (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .chanGainDb(chanGainDb),
    .indepGainActive(indepGainActive), .attenEnable(attenEnable), .attenDb(attenDb),
    .attenCodeInvalid(attenCodeInvalid), .hpfCornerKhz(hpfCornerKhz)
  );

  always #4 clk = ~clk;

  // ============================================================
  // Compare and bus tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_gain(input logic [79:0] got, input logic [79:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low; only the watchdog ends a wait on a dead slave
  task automatic bus_access(input logic isWrite, input logic [7:0] a, input logic [15:0] d,
                            output logic [31:0] rd, output logic [1:0] rsp);
    address    <= a;
    writedata  <= {16'h0000, d};
    byteenable <= 4'hF;
    write      <= isWrite;
    read       <= !isWrite;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    rsp = response;
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] rd;
    logic [1:0]  rsp;
    bus_access(1'b1, a, d, rd, rsp);
  endtask

  task automatic read_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] expRsp);
    logic [31:0] rd;
    logic [1:0]  rsp;
    bus_access(1'b0, a, 16'h0000, rd, rsp);
    chk_val(rd, exp);
    chk_val({30'h0, rsp}, {30'h0, expRsp});
  endtask

  // ============================================================
  // Expectation helpers
  function automatic logic [4:0] exp_db(input logic [1:0] c);
    case (c)
      2'b01:   exp_db = 5'h18;
      2'b10:   exp_db = 5'h0C;
      default: exp_db = 5'h12;
    endcase
  endfunction

  function automatic logic [79:0] exp_chans();
    logic [79:0] v;
    for (int i = 0; i < 16; i++) begin
      v[5*i +: 5] = indepOn ? chanExp[i] : 5'h12;
    end
    return v;
  endfunction

  task automatic check_chans();
    repeat (3) @(posedge clk);
    chk_gain(chanGainDb, exp_chans());
    chk_val({31'h0, indepGainActive}, {31'h0, indepOn});
  endtask

  // Programming happens at the write itself, so the model ignores later mode changes
  task automatic gain_write(input logic [15:0] d);
    bus_write(`IDX_PAIR_GAIN, d);
    for (int p = 0; p < 8; p++) begin
      if (!offsetOn) begin
        chanExp[2*p] = exp_db(d[2*p +: 2]);
      end
      chanExp[2*p+1] = exp_db(d[2*p +: 2]);
    end
    check_chans();
    read_check(`IDX_PAIR_GAIN, {16'h0000, d}, `RESP_OKAY);
  endtask

  task automatic tgc_case(input logic en, input logic [2:0] code, input logic [1:0] hpf);
    logic [15:0] d;
    logic [5:0]  ea;
    logic [7:0]  eh;
    d = {8'h00, en, code, hpf, 2'b00};
    ea = !en ? 6'h00 : (code == 3'b111) ? 6'h2A : {3'h0, code} * 6'h06;
    case (hpf)
      2'b00:   eh = 8'h64;
      2'b01:   eh = 8'h32;
      2'b10:   eh = 8'hC8;
      default: eh = 8'h96;
    endcase
    bus_write(`IDX_TGC_HPF, d);
    repeat (2) @(posedge clk);
    chk_val({16'h0, attenCodeInvalid, attenEnable, attenDb, hpfCornerKhz}, {16'h0, 1'b0, en, ea, eh});
    read_check(`IDX_TGC_HPF, {16'h0000, d}, `RESP_OKAY);
  endtask

  // ============================================================
  // Scenarios
  task automatic test_reset();
    chk_gain(chanGainDb, {16{5'h12}});
    chk_val({17'h0, attenEnable, attenDb, hpfCornerKhz}, {17'h0, 1'b0, 6'h00, 8'h64});
    read_check(`IDX_PAIR_GAIN, 32'h0, `RESP_OKAY);
    read_check(`IDX_TGC_HPF, 32'h0, `RESP_OKAY);
  endtask

  // Unmapped index must neither answer data nor disturb a real register
  task automatic test_unmapped();
    bus_write(8'h00, 16'hFFFF);
    read_check(8'h00, 32'h0, `RESP_DECODE_ERR);
    read_check(`IDX_TGC_HPF, 32'h0, `RESP_OKAY);
  endtask

  task automatic test_tgc();
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c < 8; c++) begin
        if (c != 6) begin
          tgc_case(e[0], c[2:0], c[1:0]);
        end
      end
    end
  endtask

  task automatic test_gain();
    gain_write(16'h6186);
    bus_write(`IDX_INDEP_GAIN, 16'h8000);
    indepOn = 1'b1;
    check_chans();
    read_check(`IDX_INDEP_GAIN, 32'h8000, `RESP_OKAY);
    // Pair 1/2 at code 01 so the 24 dB check on channel 1 is reached
    gain_write(16'h6185);
    bus_write(`IDX_OFFSET_MODE, 16'h0001);
    offsetOn = 1'b1;
    gain_write(16'h1861);
    bus_write(`IDX_INDEP_GAIN, 16'h0000);
    indepOn = 1'b0;
    check_chans();
  endtask

  // ============================================================
  // Verdict and run control
  task automatic report_and_stop();
    if (errCount == 0 && nCompared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    report_and_stop();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
    errCount = 0;
    nCompared = 0;
    offsetOn = 1'b0;
    indepOn = 1'b0;
    for (int i = 0; i < 16; i++) begin
      chanExp[i] = 5'h12;
    end
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    test_reset();
    test_unmapped();
    test_tgc();
    test_gain();
    report_and_stop();
  end

endmodule // lna_gain_tgc_hpf_cfg_regs_test
